//--- inc/sfrm_defines.svh
`ifndef SFRM_DEFINES_SVH
`define SFRM_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define SFRM_NSLOT 43
`define SFRM_PC_W 13
`define SFRM_EVT_W 5

// ----------------------------------------
// Offsets with special handling
// ----------------------------------------
`define SFRM_OFS_INDIRECT_DATA 8'h00
`define SFRM_OFS_PC_LOW 8'h02
`define SFRM_OFS_CORE_STATUS 8'h03
`define SFRM_OFS_INDIRECT_PTR 8'h04
`define SFRM_OFS_PORT_A 8'h05
`define SFRM_OFS_PORT_B 8'h06
`define SFRM_OFS_PORT_C 8'h07
`define SFRM_OFS_PORT_D 8'h08
`define SFRM_OFS_PORT_E 8'h09
`define SFRM_OFS_PC_HIGH_BUF 8'h0a
`define SFRM_OFS_CORE_INT_CTRL 8'h0b
`define SFRM_OFS_PERIPH_FLAGS_1 8'h0c
`define SFRM_OFS_PERIPH_FLAGS_2 8'h0d
`define SFRM_OFS_DIR_A 8'h85
`define SFRM_OFS_DIR_B 8'h86
`define SFRM_OFS_DIR_C 8'h87
`define SFRM_OFS_DIR_D 8'h88
`define SFRM_OFS_DIR_E 8'h89
`define SFRM_OFS_PERIPH_EN_1 8'h8c
`define SFRM_OFS_PERIPH_EN_2 8'h8d
`define SFRM_OFS_POWER_CTRL 8'h8e
`define SFRM_OFS_EVT_STATUS 8'h95
`define SFRM_OFS_EVT_MASK 8'h96

// ----------------------------------------
// Slot table: offset, bit mask, power-on value, warm-keep mask
// ----------------------------------------
`define SFRM_SPEC_TIMER0_COUNT {8'h01, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_INDIRECT_PTR {`SFRM_OFS_INDIRECT_PTR, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_PORT_A {`SFRM_OFS_PORT_A, 8'h3f, 8'h00, 8'h3f}
`define SFRM_SPEC_PORT_B {`SFRM_OFS_PORT_B, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_PORT_C {`SFRM_OFS_PORT_C, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_PORT_D {`SFRM_OFS_PORT_D, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_PORT_E {`SFRM_OFS_PORT_E, 8'h07, 8'h00, 8'h07}
`define SFRM_SPEC_PC_HIGH_BUF {`SFRM_OFS_PC_HIGH_BUF, 8'h1f, 8'h00, 8'h00}
`define SFRM_SPEC_CORE_INT_CTRL {`SFRM_OFS_CORE_INT_CTRL, 8'hff, 8'h00, 8'h01}
`define SFRM_SPEC_PERIPH_FLAGS_1 {`SFRM_OFS_PERIPH_FLAGS_1, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_PERIPH_FLAGS_2 {`SFRM_OFS_PERIPH_FLAGS_2, 8'h01, 8'h00, 8'h00}
`define SFRM_SPEC_TIMER1_LOW {8'h0e, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_TIMER1_HIGH {8'h0f, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_TIMER1_CTRL {8'h10, 8'h3f, 8'h00, 8'h3f}
`define SFRM_SPEC_TIMER2_COUNT {8'h11, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_TIMER2_CTRL {8'h12, 8'h7f, 8'h00, 8'h00}
`define SFRM_SPEC_SSER_BUF {8'h13, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_SSER_CTRL {8'h14, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_CCP1_LOW {8'h15, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_CCP1_HIGH {8'h16, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_CCP1_CTRL {8'h17, 8'h3f, 8'h00, 8'h00}
`define SFRM_SPEC_USART_RX_STAT {8'h18, 8'hf7, 8'h00, 8'h01}
`define SFRM_SPEC_USART_TX_DATA {8'h19, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_USART_RX_DATA {8'h1a, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_CCP2_LOW {8'h1b, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_CCP2_HIGH {8'h1c, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_CCP2_CTRL {8'h1d, 8'h3f, 8'h00, 8'h00}
`define SFRM_SPEC_CONV_RESULT {8'h1e, 8'hff, 8'h00, 8'hff}
`define SFRM_SPEC_CONV_CTRL_0 {8'h1f, 8'hfd, 8'h00, 8'h00}
`define SFRM_SPEC_CORE_OPTION {8'h81, 8'hff, 8'hff, 8'h00}
`define SFRM_SPEC_DIR_A {`SFRM_OFS_DIR_A, 8'h3f, 8'h3f, 8'h00}
`define SFRM_SPEC_DIR_B {`SFRM_OFS_DIR_B, 8'hff, 8'hff, 8'h00}
`define SFRM_SPEC_DIR_C {`SFRM_OFS_DIR_C, 8'hff, 8'hff, 8'h00}
`define SFRM_SPEC_DIR_D {`SFRM_OFS_DIR_D, 8'hff, 8'hff, 8'h00}
`define SFRM_SPEC_DIR_E {`SFRM_OFS_DIR_E, 8'hf7, 8'h07, 8'h00}
`define SFRM_SPEC_PERIPH_EN_1 {`SFRM_OFS_PERIPH_EN_1, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_PERIPH_EN_2 {`SFRM_OFS_PERIPH_EN_2, 8'h01, 8'h00, 8'h00}
`define SFRM_SPEC_TIMER2_PERIOD {8'h92, 8'hff, 8'hff, 8'h00}
`define SFRM_SPEC_SSER_ADDR {8'h93, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_SSER_STAT {8'h94, 8'h3f, 8'h00, 8'h00}
`define SFRM_SPEC_USART_TX_STAT {8'h98, 8'hf7, 8'h02, 8'h00}
`define SFRM_SPEC_BAUD_DIV {8'h99, 8'hff, 8'h00, 8'h00}
`define SFRM_SPEC_CONV_CTRL_1 {8'h9f, 8'h07, 8'h00, 8'h00}

// ----------------------------------------
// Core status layout and reset value
// ----------------------------------------
`define SFRM_STATUS_POR 8'h18
`define SFRM_ST_IRP 7
`define SFRM_ST_TO 4
`define SFRM_ST_PD 3

// ----------------------------------------
// Interrupt control bits
// ----------------------------------------
`define SFRM_IC_GIE 7
`define SFRM_IC_PEIE 6
`define SFRM_IC_T0IE 5
`define SFRM_IC_INTE 4
`define SFRM_IC_RBIE 3
`define SFRM_IC_T0IF 2
`define SFRM_IC_INTF 1
`define SFRM_IC_RBIF 0

// ----------------------------------------
// Power control bits and event bits
// ----------------------------------------
`define SFRM_PWR_POR 1
`define SFRM_PWR_BOR 0
`define SFRM_EVT_EXT 0
`define SFRM_EVT_WDT 1
`define SFRM_EVT_BROWN 2
`define SFRM_EVT_UNMAP 3
`define SFRM_EVT_SELF 4

`endif

//--- inc/sfrm_pkg.sv
package sfrm_pkg;

    typedef logic [7:0] sfrm_byte_t;

    typedef struct packed {
        sfrm_byte_t ofs;
        sfrm_byte_t mask;
        sfrm_byte_t por;
        sfrm_byte_t keep;
    } sfrm_spec_t;

endpackage

//--- src/sfrm_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sfrm_defines.svh"

module sfrm_top
    import sfrm_pkg::*;
#(
    parameter bit HAS_PORT_DE = 1'b1,
    parameter bit HAS_BROWN_OUT = 1'b1,
    parameter int PC_W = `SFRM_PC_W
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register bus
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Reset causes: external and watchdog are warm, brown-out is cold
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic brown_out_i,
    // Core events
    input wire logic alu_flags_we_i,
    input wire logic [2:0] alu_flags_i,
    input wire logic sleep_exec_i,
    input wire logic clrwdt_exec_i,
    input wire logic pc_step_i,
    input wire logic pc_load_i,
    input wire logic [10:0] pc_load_low_i,
    output logic [PC_W-1:0] pc_o,
    output logic [7:0] status_o,
    // Flag set strobes
    input wire logic [2:0] core_interrupt_control_set_i,
    input wire logic [7:0] peripheral_flags_1_set_i,
    input wire logic [7:0] peripheral_flags_2_set_i,
    // Indirect data memory
    output logic [8:0] mem_addr_o,
    output logic mem_wr_o,
    output logic mem_rd_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    // Port pins
    input wire logic [7:0] port_a_pin_i,
    input wire logic [7:0] port_b_pin_i,
    input wire logic [7:0] port_c_pin_i,
    input wire logic [7:0] port_d_pin_i,
    input wire logic [7:0] port_e_pin_i,
    output logic [7:0] port_a_out_o,
    output logic [7:0] port_b_out_o,
    output logic [7:0] port_c_out_o,
    output logic [7:0] port_d_out_o,
    output logic [7:0] port_e_out_o,
    output logic [7:0] port_a_dir_o,
    output logic [7:0] port_b_dir_o,
    output logic [7:0] port_c_dir_o,
    output logic [7:0] port_d_dir_o,
    output logic [7:0] port_e_dir_o,
    // Interrupts
    output logic core_irq_o,
    output logic irq_o
);

    // ----------------------------------------
    // Slot table
    // ----------------------------------------
    localparam int NSLOT = `SFRM_NSLOT;
    localparam sfrm_spec_t SPEC [NSLOT] = '{
        `SFRM_SPEC_TIMER0_COUNT, `SFRM_SPEC_INDIRECT_PTR, `SFRM_SPEC_PORT_A,
        `SFRM_SPEC_PORT_B, `SFRM_SPEC_PORT_C, `SFRM_SPEC_PORT_D, `SFRM_SPEC_PORT_E,
        `SFRM_SPEC_PC_HIGH_BUF, `SFRM_SPEC_CORE_INT_CTRL, `SFRM_SPEC_PERIPH_FLAGS_1,
        `SFRM_SPEC_PERIPH_FLAGS_2, `SFRM_SPEC_TIMER1_LOW, `SFRM_SPEC_TIMER1_HIGH,
        `SFRM_SPEC_TIMER1_CTRL, `SFRM_SPEC_TIMER2_COUNT, `SFRM_SPEC_TIMER2_CTRL,
        `SFRM_SPEC_SSER_BUF, `SFRM_SPEC_SSER_CTRL, `SFRM_SPEC_CCP1_LOW,
        `SFRM_SPEC_CCP1_HIGH, `SFRM_SPEC_CCP1_CTRL, `SFRM_SPEC_USART_RX_STAT,
        `SFRM_SPEC_USART_TX_DATA, `SFRM_SPEC_USART_RX_DATA, `SFRM_SPEC_CCP2_LOW,
        `SFRM_SPEC_CCP2_HIGH, `SFRM_SPEC_CCP2_CTRL, `SFRM_SPEC_CONV_RESULT,
        `SFRM_SPEC_CONV_CTRL_0, `SFRM_SPEC_CORE_OPTION, `SFRM_SPEC_DIR_A,
        `SFRM_SPEC_DIR_B, `SFRM_SPEC_DIR_C, `SFRM_SPEC_DIR_D, `SFRM_SPEC_DIR_E,
        `SFRM_SPEC_PERIPH_EN_1, `SFRM_SPEC_PERIPH_EN_2, `SFRM_SPEC_TIMER2_PERIOD,
        `SFRM_SPEC_SSER_ADDR, `SFRM_SPEC_SSER_STAT, `SFRM_SPEC_USART_TX_STAT,
        `SFRM_SPEC_BAUD_DIV, `SFRM_SPEC_CONV_CTRL_1
    };

    function automatic int slot_of(input sfrm_byte_t a);
        int r;
        r = 0;
        for (int i = 0; i < NSLOT; i++)
        begin
            if (SPEC[i].ofs == a)
            begin
                r = i;
            end
        end
        return r;
    endfunction

    localparam int S_PTR = slot_of(`SFRM_OFS_INDIRECT_PTR);
    localparam int S_PCH = slot_of(`SFRM_OFS_PC_HIGH_BUF);
    localparam int S_INTC = slot_of(`SFRM_OFS_CORE_INT_CTRL);
    localparam int S_PERIPHERAL_FLAGS_1 = slot_of(`SFRM_OFS_PERIPH_FLAGS_1);
    localparam int S_PERIPHERAL_FLAGS_2 = slot_of(`SFRM_OFS_PERIPH_FLAGS_2);
    localparam int S_PERIPHERAL_ENABLES_1 = slot_of(`SFRM_OFS_PERIPH_EN_1);
    localparam int S_PERIPHERAL_ENABLES_2 = slot_of(`SFRM_OFS_PERIPH_EN_2);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    sfrm_byte_t norm_a;
    logic warm;
    logic [NSLOT-1:0] slot_hit;
    sfrm_byte_t slot_q [NSLOT];
    sfrm_byte_t slot_view [NSLOT];
    logic is_indirect_data_port;
    logic is_pcl;
    logic is_stat;
    logic is_pwr;
    logic is_evs;
    logic is_evm;
    logic mapped;
    logic ptr_self;

    assign warm = ext_reset_i | wdt_reset_i;

    always_comb
    begin
        norm_a = addr_i;
        case ({1'b0, addr_i[6:0]})
            `SFRM_OFS_INDIRECT_DATA,
            `SFRM_OFS_PC_LOW,
            `SFRM_OFS_CORE_STATUS,
            `SFRM_OFS_INDIRECT_PTR,
            `SFRM_OFS_PC_HIGH_BUF,
            `SFRM_OFS_CORE_INT_CTRL: norm_a = {1'b0, addr_i[6:0]};
            default: norm_a = addr_i;
        endcase
    end

    assign is_indirect_data_port = (norm_a == `SFRM_OFS_INDIRECT_DATA);
    assign is_pcl = (norm_a == `SFRM_OFS_PC_LOW);
    assign is_stat = (norm_a == `SFRM_OFS_CORE_STATUS);
    assign is_pwr = (norm_a == `SFRM_OFS_POWER_CTRL);
    assign is_evs = (norm_a == `SFRM_OFS_EVT_STATUS);
    assign is_evm = (norm_a == `SFRM_OFS_EVT_MASK);
    assign mapped = (|slot_hit) | is_indirect_data_port | is_pcl | is_stat | is_pwr | is_evs | is_evm;
    // Pointer at the data port itself
    assign ptr_self = ({1'b0, slot_q[S_PTR][6:0]} == `SFRM_OFS_INDIRECT_DATA);

    // ----------------------------------------
    // Plain storage slots
    // ----------------------------------------
    for (genvar g = 0; g < NSLOT; g++)
    begin : g_slot
        localparam sfrm_spec_t SP = SPEC[g];
        localparam bit GONE = !HAS_PORT_DE && (SP.ofs == `SFRM_OFS_PORT_D || SP.ofs == `SFRM_OFS_PORT_E
            || SP.ofs == `SFRM_OFS_DIR_D || SP.ofs == `SFRM_OFS_DIR_E);
        sfrm_byte_t q_r;
        sfrm_byte_t q_nxt;
        sfrm_byte_t set_v;
        sfrm_byte_t pin_v;

        assign slot_hit[g] = !GONE && (norm_a == SP.ofs);
        assign slot_q[g] = q_r;

        always_comb
        begin
            case (SP.ofs)
                `SFRM_OFS_CORE_INT_CTRL: set_v = {5'h00, core_interrupt_control_set_i};
                `SFRM_OFS_PERIPH_FLAGS_1: set_v = peripheral_flags_1_set_i;
                `SFRM_OFS_PERIPH_FLAGS_2: set_v = peripheral_flags_2_set_i;
                default: set_v = 8'h00;
            endcase
            case (SP.ofs)
                `SFRM_OFS_PORT_A: pin_v = port_a_pin_i;
                `SFRM_OFS_PORT_B: pin_v = port_b_pin_i;
                `SFRM_OFS_PORT_C: pin_v = port_c_pin_i;
                `SFRM_OFS_PORT_D: pin_v = port_d_pin_i;
                `SFRM_OFS_PORT_E: pin_v = port_e_pin_i;
                default: pin_v = q_r;
            endcase
        end

        assign slot_view[g] = GONE ? 8'h00 : (pin_v & SP.mask);

        always_comb
        begin
            q_nxt = q_r;
            if (wr_i && slot_hit[g])
            begin
                q_nxt = (q_r & ~SP.mask) | (wdata_i & SP.mask);
            end
            // Set beats a clearing write
            q_nxt = q_nxt | (set_v & SP.mask);
        end

        always_ff @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                q_r <= SP.por & SP.mask;
            end
            else if (brown_out_i)
            begin
                q_r <= SP.por & SP.mask;
            end
            else if (warm)
            begin
                q_r <= ((q_r & SP.keep) | (SP.por & ~SP.keep)) & SP.mask;
            end
            else
            begin
                q_r <= q_nxt;
            end
        end
    end

    // ----------------------------------------
    // Core status
    // ----------------------------------------
    sfrm_byte_t status_r;
    sfrm_byte_t status_nxt;

    always_comb
    begin
        status_nxt = status_r;
        if (wr_i && is_stat)
        begin
            // Time-out and power-down are read-only
            status_nxt = {wdata_i[7:5], status_r[4:3], wdata_i[2:0]};
        end
        if (sleep_exec_i)
        begin
            status_nxt[`SFRM_ST_TO] = 1'b1;
            status_nxt[`SFRM_ST_PD] = 1'b0;
        end
        if (clrwdt_exec_i)
        begin
            status_nxt[`SFRM_ST_TO] = 1'b1;
            status_nxt[`SFRM_ST_PD] = 1'b1;
        end
        // ALU result flags win over a bus write
        if (alu_flags_we_i)
        begin
            status_nxt[2:0] = alu_flags_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            status_r <= `SFRM_STATUS_POR;
        end
        else if (brown_out_i)
        begin
            status_r <= `SFRM_STATUS_POR;
        end
        else if (warm)
        begin
            status_r <= {3'b000, ~wdt_reset_i & status_r[`SFRM_ST_TO], status_r[3:0]};
        end
        else
        begin
            status_r <= status_nxt;
        end
    end

    assign status_o = status_r;

    // ----------------------------------------
    // Power control flags
    // ----------------------------------------
    logic por_flag_r;
    logic bor_flag_r;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            por_flag_r <= 1'b0;
        end
        else if (wr_i && is_pwr && !brown_out_i && !warm)
        begin
            por_flag_r <= wdata_i[`SFRM_PWR_POR];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bor_flag_r <= 1'b0;
        end
        else if (brown_out_i)
        begin
            bor_flag_r <= 1'b0;
        end
        else if (wr_i && is_pwr && !warm)
        begin
            bor_flag_r <= wdata_i[`SFRM_PWR_BOR] & HAS_BROWN_OUT;
        end
    end

    // ----------------------------------------
    // Program counter
    // ----------------------------------------
    logic [PC_W-1:0] pc_r;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pc_r <= '0;
        end
        else if (brown_out_i || warm)
        begin
            pc_r <= '0;
        end
        else if (wr_i && is_pcl)
        begin
            // upper bits from the high buffer
            pc_r <= {slot_q[S_PCH][PC_W-9:0], wdata_i};
        end
        else if (pc_load_i)
        begin
            // top two bits from the high buffer
            pc_r <= {slot_q[S_PCH][PC_W-9:PC_W-10], pc_load_low_i};
        end
        else if (pc_step_i)
        begin
            pc_r <= PC_W'(pc_r + 1'b1);
        end
    end

    assign pc_o = pc_r;

    // ----------------------------------------
    // Indirect data port
    // ----------------------------------------
    // pointer-addressed access; bank bit kept clear by software
    assign mem_addr_o = {status_r[`SFRM_ST_IRP], slot_q[S_PTR]};
    assign mem_wr_o = wr_i && is_indirect_data_port && !ptr_self;
    assign mem_rd_o = rd_i && is_indirect_data_port && !ptr_self;
    assign mem_wdata_o = wdata_i;

    // ----------------------------------------
    // Event status and mask
    // ----------------------------------------
    logic [`SFRM_EVT_W-1:0] evt_r;
    logic [`SFRM_EVT_W-1:0] evt_mask_r;
    logic [`SFRM_EVT_W-1:0] evt_set;

    always_comb
    begin
        evt_set = '0;
        evt_set[`SFRM_EVT_EXT] = ext_reset_i;
        evt_set[`SFRM_EVT_WDT] = wdt_reset_i;
        evt_set[`SFRM_EVT_BROWN] = brown_out_i;
        evt_set[`SFRM_EVT_UNMAP] = wr_i && !mapped;
        evt_set[`SFRM_EVT_SELF] = (wr_i || rd_i) && is_indirect_data_port && ptr_self;
    end

    // Read clears; a new event in the same cycle survives
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            evt_r <= '0;
        end
        else
        begin
            evt_r <= (rd_i && is_evs ? '0 : evt_r) | evt_set;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            evt_mask_r <= '0;
        end
        else if (wr_i && is_evm)
        begin
            evt_mask_r <= wdata_i[`SFRM_EVT_W-1:0];
        end
    end

    assign irq_o = |(evt_r & evt_mask_r);

    // ----------------------------------------
    // Core interrupt request
    // ----------------------------------------
    sfrm_byte_t ic;
    logic periph_req;

    assign ic = slot_q[S_INTC];
    assign periph_req = |((slot_q[S_PERIPHERAL_FLAGS_1] & slot_q[S_PERIPHERAL_ENABLES_1]) | (slot_q[S_PERIPHERAL_FLAGS_2] & slot_q[S_PERIPHERAL_ENABLES_2]));
    assign core_irq_o = ic[`SFRM_IC_GIE] & ((ic[`SFRM_IC_T0IE] & ic[`SFRM_IC_T0IF])
        | (ic[`SFRM_IC_INTE] & ic[`SFRM_IC_INTF]) | (ic[`SFRM_IC_RBIE] & ic[`SFRM_IC_RBIF])
        | (ic[`SFRM_IC_PEIE] & periph_req));

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    sfrm_byte_t rd_nxt;
    sfrm_byte_t rdata_r;

    always_comb
    begin
        rd_nxt = 8'h00;
        for (int i = 0; i < NSLOT; i++)
        begin
            if (slot_hit[i])
            begin
                rd_nxt = slot_view[i];
            end
        end
        if (is_indirect_data_port && !ptr_self)
        begin
            rd_nxt = mem_rdata_i;
        end
        if (is_pcl)
        begin
            rd_nxt = pc_r[7:0];
        end
        if (is_stat)
        begin
            rd_nxt = status_r;
        end
        if (is_pwr)
        begin
            rd_nxt = {6'h00, por_flag_r, bor_flag_r};
        end
        if (is_evs)
        begin
            rd_nxt = {{(8-`SFRM_EVT_W){1'b0}}, evt_r};
        end
        if (is_evm)
        begin
            rd_nxt = {{(8-`SFRM_EVT_W){1'b0}}, evt_mask_r};
        end
    end

    // Data stands only in the cycle after the read
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rd_i ? rd_nxt : 8'h00;
        end
    end

    assign rdata_o = rdata_r;

    // ----------------------------------------
    // Port latches and directions
    // ----------------------------------------
    assign port_a_out_o = slot_q[slot_of(`SFRM_OFS_PORT_A)];
    assign port_b_out_o = slot_q[slot_of(`SFRM_OFS_PORT_B)];
    assign port_c_out_o = slot_q[slot_of(`SFRM_OFS_PORT_C)];
    assign port_d_out_o = slot_q[slot_of(`SFRM_OFS_PORT_D)];
    assign port_e_out_o = slot_q[slot_of(`SFRM_OFS_PORT_E)];
    assign port_a_dir_o = slot_q[slot_of(`SFRM_OFS_DIR_A)];
    assign port_b_dir_o = slot_q[slot_of(`SFRM_OFS_DIR_B)];
    assign port_c_dir_o = slot_q[slot_of(`SFRM_OFS_DIR_C)];
    assign port_d_dir_o = slot_q[slot_of(`SFRM_OFS_DIR_D)];
    assign port_e_dir_o = slot_q[slot_of(`SFRM_OFS_DIR_E)];

endmodule

`default_nettype wire

//--- testbench/sfrm_checker_properties.sv
`timescale 1ns/10ps
`default_nettype none
module sfrm_checker
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic ext_reset_i,
    input wire logic wdt_reset_i,
    input wire logic brown_out_i,
    input wire logic sleep_exec_i,
    input wire logic clrwdt_exec_i,
    input wire logic [12:0] pc_o,
    input wire logic [7:0] status_o,
    input wire logic [8:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] port_b_pin_i,
    input wire logic [7:0] port_b_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    idle_read_zero_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
    gp_read_zero_a: assert property (rd_i && addr_i[6:5] != 2'b00 |=> rdata_o == 8'h00) else $error("gp read");
    mem_strobe_a: assert property (mem_rd_o |-> rd_i && addr_i[6:0] == 7'h00 && mem_addr_o[6:0] != 7'h00)
        else $error("stray memory read");
    mem_data_a: assert property (mem_rd_o |=> rdata_o == $past(mem_rdata_i)) else $error("memory data");
    pc_low_write_a: assert property (wr_i && addr_i[6:0] == 7'h02 && !brown_out_i && !ext_reset_i
        && !wdt_reset_i |=> pc_o[7:0] == $past(wdata_i)) else $error("pc low write");
    latch_write_a: assert property (wr_i && addr_i == 8'h06 && !brown_out_i && !ext_reset_i && !wdt_reset_i
        |=> port_b_out_o == $past(wdata_i)) else $error("latch write");
    pin_read_a: assert property (rd_i && addr_i == 8'h06 |=> rdata_o == $past(port_b_pin_i))
        else $error("pin read");
    reset_pc_a: assert property (brown_out_i || ext_reset_i || wdt_reset_i |=> pc_o == '0)
        else $error("pc reset");
    warm_status_a: assert property (ext_reset_i && !wdt_reset_i && !brown_out_i && !wr_i && !sleep_exec_i
        && !clrwdt_exec_i |=> status_o[7:3] == {3'b000, $past(status_o[4:3])}) else $error("warm status");
    cold_status_a: assert property (brown_out_i && !sleep_exec_i && !clrwdt_exec_i |=> status_o[7:3] == 5'h03)
        else $error("cold status");
endmodule
bind sfrm_top sfrm_checker chk_u (.*);
`default_nettype wire

//--- testbench/sfrm_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfrm_mem_model
(
    input wire logic clk_i,
    input wire logic [8:0] mem_addr_o,
    input wire logic mem_wr_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_wdata_o,
    output logic [7:0] mem_rdata_i
);
    logic [7:0] mem_r [0:511];
    always_ff @(posedge clk_i)
    begin
        if (mem_wr_o)
        begin
            mem_r[mem_addr_o] <= mem_wdata_o;
        end
    end
    assign mem_rdata_i = mem_rd_o ? mem_r[mem_addr_o] : ~mem_r[mem_addr_o];
endmodule
`default_nettype wire

//--- testbench/special_function_register_map_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module special_function_register_map_tb_top;
    logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, ext_reset_i = 0, wdt_reset_i = 0, brown_out_i = 0, rnd = 0;
    logic alu_flags_we_i = 0, sleep_exec_i = 0, clrwdt_exec_i = 0, pc_step_i = 0, pc_load_i = 0;
    logic [2:0] alu_flags_i = 0, core_interrupt_control_set_i = 0;
    logic [10:0] pc_load_low_i = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, peripheral_flags_1_set_i = 0, peripheral_flags_2_set_i = 0, d, a;
    logic [7:0] port_a_pin_i = 0, port_b_pin_i = 0, port_c_pin_i = 0, port_d_pin_i = 0, port_e_pin_i = 0;
    logic [7:0] rdata_o, status_o, mem_wdata_o, mem_rdata_i, port_a_out_o, port_b_out_o, port_c_out_o;
    logic [7:0] port_d_out_o, port_e_out_o, port_a_dir_o, port_b_dir_o, port_c_dir_o, port_d_dir_o, port_e_dir_o;
    logic [12:0] pc_o;
    logic [8:0] mem_addr_o;
    logic mem_wr_o, mem_rd_o, core_irq_o, irq_o;
    logic [15:0] rv [8] = '{16'h81ff, 16'h853f, 16'h86ff, 16'h8907, 16'h92ff, 16'h9802, 16'h0318, 16'h8e00};
    int n_errors = 0, total_checks = 0, cyc = 0;
    sfrm_top DUT (.*);
    sfrm_mem_model mem_u (.*);
    logic [7:0] lite_rdata;
    // reduced build beside the full one
    sfrm_top #(.HAS_PORT_DE(1'b0), .HAS_BROWN_OUT(1'b0)) lite_u (.*, .rdata_o(lite_rdata), .pc_o(), .status_o(),
        .mem_addr_o(), .mem_wr_o(), .mem_rd_o(), .mem_wdata_o(), .port_a_out_o(), .port_b_out_o(), .port_c_out_o(),
        .port_d_out_o(), .port_e_out_o(), .port_a_dir_o(), .port_b_dir_o(), .port_c_dir_o(), .port_d_dir_o(),
        .port_e_dir_o(), .core_irq_o(), .irq_o());
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) {port_a_pin_i, port_b_pin_i, port_c_pin_i, port_d_pin_i, port_e_pin_i} <=
        40'({$urandom, $urandom});
    always @(posedge clk_i) if (rnd) {alu_flags_we_i, alu_flags_i, sleep_exec_i, clrwdt_exec_i, pc_step_i, pc_load_i,
        pc_load_low_i, core_interrupt_control_set_i, peripheral_flags_1_set_i, peripheral_flags_2_set_i} <= 38'({$urandom, $urandom}) & 38'h3f_ffff_7fff;
    task close_out;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_errors++;
            close_out;
        end
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] dt);
        addr_i <= ad;
        wdata_i <= dt;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Reduced build: ports D/E gone, brown-out flag reads zero
    function automatic logic [7:0] lite_exp(input logic [7:0] ad, input logic [7:0] e);
        if (ad == 8'h08 || ad == 8'h09 || ad == 8'h88 || ad == 8'h89)
            return 8'h00;
        return (ad == 8'h8e) ? (e & 8'hfe) : e;
    endfunction
    task rc(input logic [7:0] ad, input logic [7:0] e);
        addr_i <= ad;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, e);
        chk(lite_rdata, lite_exp(ad, e));
        @(posedge clk_i);
    endtask
    // Pins move every edge: expect what stood at the read's edge
    task rp;
        addr_i <= 8'h06;
        rd_i <= 1'b1;
        @(posedge clk_i);
        a = port_b_pin_i;
        rd_i <= 1'b0;
        #1 chk(rdata_o, a);
        chk(lite_rdata, a);
        @(posedge clk_i);
    endtask
    task rst(input logic [2:0] k);
        {brown_out_i, wdt_reset_i, ext_reset_i} <= k;
        @(posedge clk_i);
        {brown_out_i, wdt_reset_i, ext_reset_i} <= 3'b000;
        @(posedge clk_i);
    endtask
    initial
    begin
        void'($urandom(32'hf3c6));
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        foreach (rv[i]) rc(rv[i][15:8], rv[i][7:0]);
        chk(port_a_dir_o, 8'h3f);
        wr(8'h84, 8'h25);
        rc(8'h04, 8'h25);
        d = 8'($urandom);
        wr(8'h00, d);
        rc(8'h80, d);
        wr(8'h04, 8'h80);
        rc(8'h00, 8'h00);
        wr(8'h96, 8'h18);
        wr(8'h30, 8'hff);
        chk(irq_o, 1'b1);
        rc(8'h95, 8'h18);
        chk(irq_o, 1'b0);
        wr(8'h96, 8'h10);
        wr(8'h8f, 8'hff);
        chk(irq_o, 1'b0);
        rc(8'h95, 8'h08);
        wr(8'h0a, 8'hff);
        rc(8'h8a, 8'h1f);
        pc_load_low_i <= 11'h5a5;
        pc_load_i <= 1'b1;
        @(posedge clk_i);
        pc_load_i <= 1'b0;
        #1 chk(pc_o, 16'h1da5);
        wr(8'h81, 8'h00);
        rst(3'b001);
        chk(pc_o, 16'h0000);
        rc(8'h04, 8'h80);
        rc(8'h81, 8'hff);
        rst(3'b010);
        rc(8'h03, 8'h08);
        wr(8'h8e, 8'h03);
        rc(8'h8e, 8'h03);
        rst(3'b100);
        rc(8'h83, 8'h18);
        rc(8'h8e, 8'h02);
        rc(8'h04, 8'h00);
        wr(8'h03, 8'h20);
        rc(8'h83, 8'h38);
        wr(8'h8b, 8'ha4);
        chk(core_irq_o, 1'b1);
        wr(8'h0b, 8'h00);
        chk(core_irq_o, 1'b0);
        rnd <= 1'b1;
        repeat (150)
        begin
            d = 8'($urandom);
            a = 8'($urandom) | 8'h20;
            wr(8'h06, d);
            chk(port_b_out_o, d);
            rc(a, 8'h00);
            wr(8'h82, d);
            rp;
        end
        close_out;
    end
endmodule
`default_nettype wire
